// >>> hdl/swud_dev.sv
// node end of the single wire datagram link: receive, check, write, reply
// assumes an idle-high wire and a host keeping the framing and release timing
//
// Function
// - checksum polynomial x^8+x^2+x+1, 8 bits
// - checksum starts zero, all bytes but last
// - msb xor bit set: shift, xor 07
// - act only on good checksum, own address
// - count accepted writes, reads leave count
// - one non-inverted pin for receive and reply
// - node address from two straps, lsb first
// - bit time measured from each sync nibble
// - reply at the request's bit rate
// - release driver four bit times after stop
// - four node addresses share one wire
// - host frames bytes 8N1, eighty bits per write
// - host releases wire after last stop bit
// - host discards echo of its own bytes
// - all state loaded from RST at power up
// - address bit 7 set marks a write
// - replies carry the all-ones address byte
// - reply delay in steps of eight bits
// - long gap resets, twelve idle bits recover
// - write counter eight bits, wraps around
`timescale 1ns/1ns
`include "swud_defs.svh"

module swud_dev #(
	parameter logic [15:0] BIT_INIT = `SWUD_BIT_INIT
) (
	input  wire logic        core_clk_i,
	input  wire logic        rstn_i,
	swud_link_if.dev         link,
	input  wire logic        node_addr_strap_lsb_i,
	input  wire logic        node_addr_strap_msb_i,
	input  wire logic [3:0]  reply_delay_setting_i,
	input  wire logic [31:0] rd_data_i,
	output logic      [6:0]  rd_addr_o,
	output logic             wr_stb_o,
	output logic      [6:0]  wr_addr_o,
	output logic      [31:0] wr_data_o,
	output logic      [7:0]  accept_count_o
);

	localparam swud_pkg::swud_dev_q_t RST = '{st: swud_pkg::DS_IDLE, line_s: 3'h7,
		ln: 1'h1, ln_d: 1'h1, bit_time: BIT_INIT, frame: 10'h3FF, oe_n: 1'h1,
		default: '0};

	swud_pkg::swud_dev_q_t q_reg;
	swud_pkg::swud_dev_q_t q_next;
	logic                  fall;
	logic                  timeout;
	logic                  last;
	logic [7:0]            b;
	logic [7:0]            delay_bits;

	// byte k of the reply datagram
	function automatic logic [7:0] reply_byte(input logic [2:0] k, input swud_pkg::swud_dev_q_t s);
		case (k)
			3'h0: return `SWUD_SYNC_BYTE;
			3'h1: return `SWUD_REPLY_ADDR;
			3'h2: return {1'h0, s.reg_addr[6:0]};
			3'h3: return s.data[31:24];
			3'h4: return s.data[23:16];
			3'h5: return s.data[15:8];
			3'h6: return s.data[7:0];
			default: return s.crc;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// outputs straight from state
	assign link.dev_tx     = q_reg.frame[0];
	assign link.dev_oe_n   = q_reg.oe_n;
	assign rd_addr_o       = q_reg.reg_addr[6:0];
	assign wr_stb_o        = q_reg.wr_stb;
	assign wr_addr_o       = q_reg.reg_addr[6:0];
	assign wr_data_o       = q_reg.wr_data;
	assign accept_count_o  = q_reg.acc_cnt;

	// helper terms from current state and the reply delay setting input
	assign fall       = q_reg.ln_d & ~q_reg.ln;
	assign timeout    = q_reg.gap > swud_pkg::bit_cycles(q_reg.bit_time, `SWUD_GAP_BITS);
	assign b          = q_reg.shreg;
	assign last       = (q_reg.byte_no == `SWUD_WR_LAST)
		|| (q_reg.byte_no == `SWUD_RD_LAST && !q_reg.reg_addr[`SWUD_WR_BIT]);
	assign delay_bits = 8'(({4'h0, reply_delay_setting_i} + 8'h01) * `SWUD_DELAY_STEP);

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		q_next        = q_reg;
		q_next.wr_stb = 1'h0;
		// pin synchronisers; a level counts once second and third agree
		q_next.line_s  = {q_reg.line_s[1:0], link.line};
		q_next.strap_s = {q_reg.strap_s[3:0], node_addr_strap_msb_i, node_addr_strap_lsb_i};
		if (q_reg.line_s[1] == q_reg.line_s[2]) begin
			q_next.ln = q_reg.line_s[2];
		end
		if (q_reg.strap_s[3:2] == q_reg.strap_s[5:4]) begin
			q_next.node = q_reg.strap_s[5:4];
		end
		q_next.ln_d = q_reg.ln;
		q_next.gap  = q_reg.gap + 24'h1;
		case (q_reg.st)
			swud_pkg::DS_IDLE: begin
				// first falling edge opens a datagram
				if (fall) begin
					q_next.st      = swud_pkg::DS_SYNC;
					q_next.cnt     = '0;
					q_next.gap     = '0;
					q_next.falls   = 1'h0;
					q_next.crc     = '0;
					q_next.byte_no = '0;
				end
			end
			swud_pkg::DS_SYNC: begin
				q_next.cnt = q_reg.cnt + 24'h1;
				if (timeout) begin
					q_next.st  = swud_pkg::DS_RECOVER;
					q_next.cnt = '0;
				end else if (fall && !q_reg.falls) begin
					q_next.falls = 1'h1;
				end else if (fall) begin
					// start edge to bit 3 edge spans four bit times
					q_next.bit_time = 16'((q_reg.cnt + 24'h1) >> 2);
					q_next.shreg    = `SWUD_SYNC_SEED;
					q_next.idx      = 4'h3;
					q_next.cnt      = (q_reg.cnt + 24'h1) >> 3;
					q_next.st       = swud_pkg::DS_BIT;
				end
			end
			swud_pkg::DS_BIT: begin
				if (timeout) begin
					q_next.st  = swud_pkg::DS_RECOVER;
					q_next.cnt = '0;
				end else if (q_reg.cnt != '0) begin
					q_next.cnt = q_reg.cnt - 24'h1;
				end else if (q_reg.idx != `SWUD_RX_STOP_IDX) begin
					q_next.shreg = {q_reg.ln, q_reg.shreg[7:1]};
					q_next.idx   = q_reg.idx + 4'h1;
					q_next.cnt   = 24'(q_reg.bit_time) - 24'h1;
				end else if (!q_reg.ln) begin
					q_next.st  = swud_pkg::DS_RECOVER;
					q_next.cnt = '0;
				end else if (last) begin
					if (b != q_reg.crc) begin
						q_next.st  = swud_pkg::DS_RECOVER;
						q_next.cnt = '0;
					end else if (!q_reg.addr_ok) begin
						q_next.st = swud_pkg::DS_IDLE;
					end else if (q_reg.reg_addr[`SWUD_WR_BIT]) begin
						q_next.wr_stb  = 1'h1;
						q_next.wr_data = q_reg.data;
						q_next.acc_cnt = q_reg.acc_cnt + 8'h01;
						q_next.st      = swud_pkg::DS_IDLE;
					end else begin
						q_next.cnt = swud_pkg::bit_cycles(q_reg.bit_time, delay_bits);
						q_next.st  = swud_pkg::DS_DELAY;
					end
				end else begin
					// fold byte into checksum and datagram fields
					q_next.crc     = swud_pkg::crc_byte(q_reg.crc, b);
					q_next.byte_no = q_reg.byte_no + 3'h1;
					if (q_reg.byte_no == 3'h1) begin
						q_next.addr_ok = (b == {6'h00, q_reg.node});
					end
					if (q_reg.byte_no == 3'h2) begin
						q_next.reg_addr = b;
					end
					if (q_reg.byte_no > 3'h2) begin
						q_next.data = {q_reg.data[23:0], b};
					end
					q_next.st = swud_pkg::DS_GAP;
				end
			end
			swud_pkg::DS_GAP: begin
				if (timeout) begin
					q_next.st  = swud_pkg::DS_RECOVER;
					q_next.cnt = '0;
				end else if (fall) begin
					// skip start bit, sample mid bit 0
					q_next.gap = '0;
					q_next.idx = '0;
					q_next.cnt = 24'(q_reg.bit_time) + 24'(q_reg.bit_time >> 1) - 24'h1;
					q_next.st  = swud_pkg::DS_BIT;
				end
			end
			swud_pkg::DS_RECOVER: begin
				// wait for an unbroken idle stretch
				q_next.cnt = q_reg.ln ? q_reg.cnt + 24'h1 : '0;
				if (q_reg.cnt >= swud_pkg::bit_cycles(q_reg.bit_time, `SWUD_RECOVER_BITS)) begin
					q_next.st = swud_pkg::DS_IDLE;
				end
			end
			swud_pkg::DS_DELAY: begin
				if (q_reg.cnt != '0) begin
					q_next.cnt = q_reg.cnt - 24'h1;
				end else begin
					// read data taken here; user has the whole delay to settle it
					q_next.data    = rd_data_i;
					q_next.crc     = swud_pkg::crc_byte(8'h00, `SWUD_SYNC_BYTE);
					q_next.frame   = {1'h1, `SWUD_SYNC_BYTE, 1'h0};
					q_next.byte_no = '0;
					q_next.idx     = '0;
					q_next.cnt     = 24'(q_reg.bit_time) - 24'h1;
					q_next.oe_n    = 1'h0;
					q_next.st      = swud_pkg::DS_TX;
				end
			end
			swud_pkg::DS_TX: begin
				if (q_reg.cnt != '0) begin
					q_next.cnt = q_reg.cnt - 24'h1;
				end else begin
					q_next.cnt = 24'(q_reg.bit_time) - 24'h1;
					if (q_reg.idx != `SWUD_TX_STOP_IDX) begin
						q_next.frame = {1'h1, q_reg.frame[9:1]};
						q_next.idx   = q_reg.idx + 4'h1;
					end else if (q_reg.byte_no == `SWUD_WR_LAST) begin
						q_next.cnt = swud_pkg::bit_cycles(q_reg.bit_time, `SWUD_HOLD_BITS)
							- 24'h1;
						q_next.st  = swud_pkg::DS_HOLD;
					end else begin
						q_next.frame   = {1'h1, reply_byte(q_reg.byte_no + 3'h1, q_reg), 1'h0};
						q_next.crc     = swud_pkg::crc_byte(q_reg.crc,
							reply_byte(q_reg.byte_no + 3'h1, q_reg));
						q_next.byte_no = q_reg.byte_no + 3'h1;
						q_next.idx     = '0;
					end
				end
			end
			swud_pkg::DS_HOLD: begin
				if (q_reg.cnt != '0) begin
					q_next.cnt = q_reg.cnt - 24'h1;
				end else begin
					q_next.oe_n = 1'h1;
					q_next.st   = swud_pkg::DS_IDLE;
				end
			end
			default: begin
				q_next.st = swud_pkg::DS_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// state register, loaded from RST at power up
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q_reg <= RST;
		end else begin
			q_reg <= q_next;
		end
	end

endmodule

// >>> include/swud_defs.svh
// constants of the single wire datagram link: framing, checksum, timing
// assumes a 25 MHz core clock shared by both ends
`ifndef SWUD_DEFS_SVH
`define SWUD_DEFS_SVH

`define SWUD_CLK_NS        40
`define SWUD_SYNC_BYTE     8'h05
`define SWUD_SYNC_SEED     8'hA0
`define SWUD_REPLY_ADDR    8'hFF
`define SWUD_CRC_POLY      8'h07
`define SWUD_WR_BIT        7
`define SWUD_WR_LAST       3'h7
`define SWUD_RD_LAST       3'h3
`define SWUD_RX_STOP_IDX   4'h8
`define SWUD_TX_STOP_IDX   4'h9
`define SWUD_GAP_BITS      8'h3F
`define SWUD_RECOVER_BITS  8'h0C
`define SWUD_HOLD_BITS     8'h04
`define SWUD_DELAY_STEP    8'h08
`define SWUD_BIT_INIT      16'h0AD9
`define SWUD_HOST_BIT_NS   4000
`define SWUD_HOST_BIT_CYC  (`SWUD_HOST_BIT_NS / `SWUD_CLK_NS)
`define SWUD_HOST_TMO_BITS 200

`endif

// >>> include/swud_pkg.sv
// types and shared arithmetic of the single wire datagram link
// assumes swud_defs.svh on the include path
`include "swud_defs.svh"

package swud_pkg;

	typedef enum logic [3:0] {DS_IDLE, DS_SYNC, DS_BIT, DS_GAP, DS_RECOVER,
		DS_DELAY, DS_TX, DS_HOLD} swud_dev_state_t;

	typedef enum logic [1:0] {HS_IDLE, HS_TX, HS_WAIT, HS_BIT} swud_host_state_t;

	typedef struct packed {
		swud_dev_state_t st;
		logic [2:0]      line_s;
		logic            ln;
		logic            ln_d;
		logic [5:0]      strap_s;
		logic [1:0]      node;
		logic [15:0]     bit_time;
		logic [23:0]     cnt;
		logic [23:0]     gap;
		logic            falls;
		logic [3:0]      idx;
		logic [7:0]      shreg;
		logic [2:0]      byte_no;
		logic            addr_ok;
		logic [7:0]      reg_addr;
		logic [31:0]     data;
		logic [7:0]      crc;
		logic [9:0]      frame;
		logic            oe_n;
		logic            wr_stb;
		logic [31:0]     wr_data;
		logic [7:0]      acc_cnt;
	} swud_dev_q_t;

	typedef struct packed {
		swud_host_state_t st;
		logic [2:0]       line_s;
		logic             ln;
		logic             ln_d;
		logic [23:0]      cnt;
		logic [3:0]       idx;
		logic [2:0]       byte_no;
		logic [9:0]       frame;
		logic             oe_n;
		logic [7:0]       crc;
		logic             write;
		logic [1:0]       node;
		logic [6:0]       regb;
		logic [31:0]      data;
		logic [7:0]       shreg;
		logic             bad;
		logic             ready;
		logic             rsp_valid;
		logic             rsp_err;
	} swud_host_q_t;

	// checksum over one byte, fed lsb first
	function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] x;
		x = c;
		for (int i = 0; i < 8; i++) begin
			if (x[7] ^ b[i]) begin
				x = {x[6:0], 1'h0} ^ `SWUD_CRC_POLY;
			end else begin
				x = {x[6:0], 1'h0};
			end
		end
		return x;
	endfunction

	// cycles spanned by n bit times
	function automatic logic [23:0] bit_cycles(input logic [15:0] bt, input logic [7:0] n);
		return 24'(bt) * 24'(n);
	endfunction

endpackage

// >>> include/swud_link_if.sv
// shared single wire between the node end and the host end
// assumes an idle-high pulled-up wire; a driver with enable low pulls it
`timescale 1ns/1ns

interface swud_link_if;
	logic dev_tx;
	logic dev_oe_n;
	logic host_tx;
	logic host_oe_n;
	logic line;

	// wired level: any enabled driver sending low wins, else pulled high
	assign line = (dev_oe_n | dev_tx) & (host_oe_n | host_tx);

	modport dev (input line, output dev_tx, output dev_oe_n);
	modport host (input line, output host_tx, output host_oe_n);
endinterface

// >>> hdl/swud_host.sv
// host end of the single wire datagram link: sends writes and read requests
// assumes a node end on the same wire answering reads at the host bit rate
`timescale 1ns/1ns
`include "swud_defs.svh"

module swud_host #(
	parameter logic [23:0] TMO_CYC = 24'(`SWUD_HOST_TMO_BITS * `SWUD_HOST_BIT_CYC)
) (
	input  wire logic        core_clk_i,
	input  wire logic        rstn_i,
	swud_link_if.host        link,
	input  wire logic        cmd_valid_i,
	input  wire logic        cmd_write_i,
	input  wire logic [1:0]  cmd_node_i,
	input  wire logic [6:0]  cmd_reg_i,
	input  wire logic [31:0] cmd_data_i,
	output logic             cmd_ready_o,
	output logic             rsp_valid_o,
	output logic             rsp_err_o,
	output logic      [31:0] rsp_data_o
);

	localparam logic [23:0] HBIT = 24'(`SWUD_HOST_BIT_CYC);
	localparam swud_pkg::swud_host_q_t RST = '{st: swud_pkg::HS_IDLE, line_s: 3'h7,
		ln: 1'h1, ln_d: 1'h1, frame: 10'h3FF, oe_n: 1'h1, default: '0};

	swud_pkg::swud_host_q_t q_reg;
	swud_pkg::swud_host_q_t q_next;
	logic                   fall;
	logic [2:0]             last_idx;
	logic [7:0]             b;

	// byte k of the outgoing datagram
	function automatic logic [7:0] req_byte(input logic [2:0] k, input swud_pkg::swud_host_q_t s,
		input logic [2:0] lst);
		if (k == lst) begin
			return s.crc;
		end
		case (k)
			3'h0: return `SWUD_SYNC_BYTE;
			3'h1: return {6'h00, s.node};
			3'h2: return {s.write, s.regb};
			3'h3: return s.data[31:24];
			3'h4: return s.data[23:16];
			3'h5: return s.data[15:8];
			default: return s.data[7:0];
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// outputs straight from state
	assign link.host_tx   = q_reg.frame[0];
	assign link.host_oe_n = q_reg.oe_n;
	assign cmd_ready_o    = q_reg.ready;
	assign rsp_valid_o    = q_reg.rsp_valid;
	assign rsp_err_o      = q_reg.rsp_err;
	assign rsp_data_o     = q_reg.data;

	assign fall     = q_reg.ln_d & ~q_reg.ln;
	assign last_idx = q_reg.write ? `SWUD_WR_LAST : `SWUD_RD_LAST;
	assign b        = q_reg.shreg;

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		q_next           = q_reg;
		q_next.rsp_valid = 1'h0;
		q_next.line_s    = {q_reg.line_s[1:0], link.line};
		if (q_reg.line_s[1] == q_reg.line_s[2]) begin
			q_next.ln = q_reg.line_s[2];
		end
		q_next.ln_d = q_reg.ln;
		case (q_reg.st)
			swud_pkg::HS_IDLE: begin
				q_next.ready = 1'h1;
				if (cmd_valid_i && q_reg.ready) begin
					// each command is one datagram addressed to the node in cmd_node_i
					q_next.write   = cmd_write_i;
					q_next.node    = cmd_node_i;
					q_next.regb    = cmd_reg_i;
					q_next.data    = cmd_data_i;
					q_next.ready   = 1'h0;
					q_next.crc     = swud_pkg::crc_byte(8'h00, `SWUD_SYNC_BYTE);
					q_next.frame   = {1'h1, `SWUD_SYNC_BYTE, 1'h0};
					q_next.oe_n    = 1'h0;
					q_next.idx     = '0;
					q_next.byte_no = '0;
					q_next.cnt     = HBIT - 24'h1;
					q_next.st      = swud_pkg::HS_TX;
				end
			end
			swud_pkg::HS_TX: begin
				// receiver idle while sending, so the echo is dropped
				if (q_reg.cnt != '0) begin
					q_next.cnt = q_reg.cnt - 24'h1;
				end else begin
					q_next.cnt = HBIT - 24'h1;
					if (q_reg.idx != `SWUD_TX_STOP_IDX) begin
						q_next.frame = {1'h1, q_reg.frame[9:1]};
						q_next.idx   = q_reg.idx + 4'h1;
					end else if (q_reg.byte_no == last_idx) begin
						q_next.oe_n    = 1'h1;
						q_next.cnt     = '0;
						q_next.byte_no = '0;
						q_next.crc     = '0;
						q_next.bad     = 1'h0;
						if (q_reg.write) begin
							q_next.rsp_valid = 1'h1;
							q_next.rsp_err   = 1'h0;
							q_next.st        = swud_pkg::HS_IDLE;
						end else begin
							q_next.st = swud_pkg::HS_WAIT;
						end
					end else begin
						q_next.frame   = {1'h1, req_byte(q_reg.byte_no + 3'h1, q_reg, last_idx),
							1'h0};
						q_next.crc     = swud_pkg::crc_byte(q_reg.crc,
							req_byte(q_reg.byte_no + 3'h1, q_reg, last_idx));
						q_next.byte_no = q_reg.byte_no + 3'h1;
						q_next.idx     = '0;
					end
				end
			end
			swud_pkg::HS_WAIT: begin
				q_next.cnt = q_reg.cnt + 24'h1;
				if (q_reg.cnt >= TMO_CYC) begin
					q_next.rsp_valid = 1'h1;
					q_next.rsp_err   = 1'h1;
					q_next.st        = swud_pkg::HS_IDLE;
				end else if (fall) begin
					q_next.cnt = HBIT + (HBIT >> 1) - 24'h1;
					q_next.idx = '0;
					q_next.st  = swud_pkg::HS_BIT;
				end
			end
			swud_pkg::HS_BIT: begin
				if (q_reg.cnt != '0) begin
					q_next.cnt = q_reg.cnt - 24'h1;
				end else if (q_reg.idx != `SWUD_RX_STOP_IDX) begin
					q_next.shreg = {q_reg.ln, q_reg.shreg[7:1]};
					q_next.idx   = q_reg.idx + 4'h1;
					q_next.cnt   = HBIT - 24'h1;
				end else if (q_reg.byte_no == `SWUD_WR_LAST || !q_reg.ln) begin
					q_next.rsp_valid = 1'h1;
					q_next.rsp_err   = q_reg.bad || !q_reg.ln || (b != q_reg.crc);
					q_next.st        = swud_pkg::HS_IDLE;
				end else begin
					q_next.crc     = swud_pkg::crc_byte(q_reg.crc, b);
					q_next.byte_no = q_reg.byte_no + 3'h1;
					if (q_reg.byte_no == 3'h1 && b != `SWUD_REPLY_ADDR) begin
						q_next.bad = 1'h1;
					end
					if (q_reg.byte_no > 3'h2) begin
						q_next.data = {q_reg.data[23:0], b};
					end
					q_next.cnt = '0;
					q_next.st  = swud_pkg::HS_WAIT;
				end
			end
			default: begin
				q_next.st = swud_pkg::HS_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q_reg <= RST;
		end else begin
			q_reg <= q_next;
		end
	end

endmodule

// >>> verif/swud_link_monitor.sv
// checker of the shared wire between the node end and the host end
// assumes a 100 cycle bit time and reply delay setting 1 on the node
`timescale 1ns/1ns

module swud_link_monitor (
	input  wire logic core_clk_i,
	input  wire logic rstn_i,
	input  wire logic dev_tx,
	input  wire logic dev_oe_n,
	input  wire logic host_tx,
	input  wire logic host_oe_n,
	input  wire logic line
);
	logic [15:0] drv_cnt;
	logic [15:0] rel_cnt;

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	////////////////////////////////////////////////////////////////////////////////
	// cycles the node has driven the wire, and cycles since the host let go
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			drv_cnt <= 16'h0000;
			rel_cnt <= 16'h0000;
		end else begin
			drv_cnt <= dev_oe_n ? 16'h0000 : drv_cnt + 16'h0001;
			rel_cnt <= !host_oe_n ? 16'h0000 :
				((rel_cnt == 16'hFFFF) ? rel_cnt : rel_cnt + 16'h0001);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// node side of the wire
	// eight frames of ten bits, then four idle bits before letting go
	drv_release_a: assert property ($rose(dev_oe_n) |->
		drv_cnt >= 16'h20C6 && drv_cnt <= 16'h20DA) else $error("node release time wrong");
	start_low_a: assert property ($fell(dev_oe_n) |-> ##[0:1] !dev_tx)
		else $error("node reply does not open with a start bit");
	reply_delay_a: assert property ($fell(dev_oe_n) |->
		rel_cnt >= 16'h05DC && rel_cnt <= 16'h0672) else $error("reply delay wrong");
	dev_idle_a: assert property (dev_oe_n |-> dev_tx)
		else $error("node drive value not idle high");
	bit_stable_a: assert property (!dev_oe_n && $changed(dev_tx) |=> $stable(dev_tx)[*8])
		else $error("node bit shorter than bit time");
	no_clash_a: assert property (!(!dev_oe_n && !host_oe_n))
		else $error("both ends drive the wire");

	////////////////////////////////////////////////////////////////////////////////
	// host side of the wire
	host_release_a: assert property ($rose(host_oe_n) |-> $past(host_tx))
		else $error("host released before stop bit");
	host_start_a: assert property ($fell(host_oe_n) |-> !host_tx)
		else $error("host frame does not open with a start bit");

	// main scenarios
	cover property ($rose(host_oe_n));
	cover property ($fell(dev_oe_n));
	cover property ($rose(dev_oe_n));
	cover property (!dev_oe_n && !line);
endmodule

// >>> verif/single_wire_uart_datagram_slave_test.sv
// testbench joining node end and host end over the shared wire
// a second node on its own wire is fed raw datagrams by the bench
`timescale 1ns/1ns

module single_wire_uart_datagram_slave_test;
	logic        clk;
	logic        rstn;
	logic        cmd_valid;
	logic        cmd_write;
	logic [1:0]  cmd_node;
	logic [6:0]  cmd_reg;
	logic [31:0] cmd_data;
	logic [31:0] rd_data;
	logic        strap_lsb;
	logic        strap_msb;
	logic [3:0]  dly;
	logic [1:0]  strap2;
	logic        cmd_ready;
	logic        rsp_valid;
	logic        rsp_err;
	logic [31:0] rsp_data;
	logic [31:0] wr_data;
	logic [6:0]  rd_addr;
	logic [6:0]  wr_addr;
	logic        wr_stb;
	logic [7:0]  acc;
	logic [7:0]  acc2;
	logic [9:0]  f;
	int          n_mismatch;
	int          checks;
	int          n_stb;

	swud_link_if lk();
	swud_link_if lk2();

	swud_dev #(.BIT_INIT(16'h0064)) swud_dev_i (.core_clk_i(clk), .rstn_i(rstn), .link(lk.dev),
		.node_addr_strap_lsb_i(strap_lsb), .node_addr_strap_msb_i(strap_msb),
		.reply_delay_setting_i(dly), .rd_data_i(rd_data), .rd_addr_o(rd_addr),
		.wr_stb_o(wr_stb), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .accept_count_o(acc));
	swud_dev #(.BIT_INIT(16'h0064)) swud_dev_bad_i (.core_clk_i(clk), .rstn_i(rstn),
		.link(lk2.dev), .node_addr_strap_lsb_i(strap2[0]), .node_addr_strap_msb_i(strap2[1]),
		.reply_delay_setting_i(dly), .rd_data_i(rd_data), .rd_addr_o(), .wr_stb_o(),
		.wr_addr_o(), .wr_data_o(), .accept_count_o(acc2));
	swud_host #(.TMO_CYC(24'h000BB8)) swud_host_i (.core_clk_i(clk), .rstn_i(rstn),
		.link(lk.host), .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_node_i(cmd_node),
		.cmd_reg_i(cmd_reg), .cmd_data_i(cmd_data), .cmd_ready_o(cmd_ready),
		.rsp_valid_o(rsp_valid), .rsp_err_o(rsp_err), .rsp_data_o(rsp_data));
	swud_link_monitor swud_link_monitor_i (.core_clk_i(clk), .rstn_i(rstn), .dev_tx(lk.dev_tx),
		.dev_oe_n(lk.dev_oe_n), .host_tx(lk.host_tx), .host_oe_n(lk.host_oe_n), .line(lk.line));

	////////////////////////////////////////////////////////////////////////////////
	// clock, write strobe counter, watchdog
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(negedge clk) begin
		if (wr_stb === 1'b1) n_stb++;
	end
	initial begin
		repeat (80000) @(posedge clk);
		n_mismatch++;
		final_report;
	end

	////////////////////////////////////////////////////////////////////////////////
	// compare, checksum, bus tasks
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			c = (c[7] ^ b[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
		end
		return c;
	endfunction

	// one host command, waits for its response pulse
	task automatic do_cmd(input logic w, input logic [1:0] n, input logic [6:0] r,
		input logic [31:0] d);
		int k;
		k = 0;
		@(negedge clk);
		while (cmd_ready !== 1'b1 && k < 100) begin
			@(negedge clk);
			k++;
		end
		if (k == 100) begin
			n_mismatch++;
			$display("[ERR] cmd_ready expected 1 seen 0");
		end
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_node = n;
		cmd_reg = r;
		cmd_data = d;
		@(negedge clk);
		cmd_valid = 1'b0;
		k = 0;
		while (rsp_valid !== 1'b1 && k < 20000) begin
			@(negedge clk);
			k++;
		end
		if (k == 20000) begin
			n_mismatch++;
			$display("[ERR] rsp_valid expected 1 seen 0");
		end
	endtask

	// samples one 8N1 frame off the main wire, start bit in f[0]
	task automatic rx_byte(output logic [9:0] fr);
		while (lk.line !== 1'b1) @(negedge clk);
		while (lk.line !== 1'b0) @(negedge clk);
		repeat (50) @(negedge clk);
		for (int i = 0; i < 10; i++) begin
			fr[i] = lk.line;
			if (i < 9) repeat (100) @(negedge clk);
		end
	endtask

	// raw byte on the second wire, lsb first, 100 cycles a bit
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			lk2.host_tx = fr[i];
			repeat (100) @(negedge clk);
		end
	endtask

	// write datagram to node 0, checksum bits flipped by flip
	task automatic send_dg(input logic [7:0] flip);
		logic [7:0] d [7];
		logic [7:0] c;
		d = '{8'h05, 8'h00, 8'h81, 8'h11, 8'h22, 8'h33, 8'h44};
		c = 8'h00;
		@(negedge clk);
		lk2.host_oe_n = 1'b0;
		for (int i = 0; i < 7; i++) begin
			c = crc8(c, d[i]);
			send_byte(d[i]);
		end
		send_byte(c ^ flip);
		lk2.host_oe_n = 1'b1;
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// tests
	initial begin
		rstn = 1'b0;
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_node = 2'h0;
		cmd_reg = 7'h00;
		cmd_data = 32'h00000000;
		rd_data = 32'h13579BDF;
		strap_lsb = 1'b0;
		strap_msb = 1'b1;
		dly = 4'h1;
		strap2 = 2'h0;
		lk2.host_oe_n = 1'b1;
		lk2.host_tx = 1'b1;
		n_mismatch = 0;
		checks = 0;
		n_stb = 0;
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		repeat (10) @(negedge clk);
		chk("accept_count", 32'h00000000, 32'(acc));
		// write to node 2, the strap value msb set, lsb clear
		fork
			do_cmd(1'b1, 2'h2, 7'h12, 32'h89ABCDEF);
			rx_byte(f);
		join
		repeat (300) @(negedge clk);
		chk("sync frame", 32'h0000020A, 32'(f));
		chk("rsp_err", 32'h00000000, 32'(rsp_err));
		chk("wr_stb count", 32'h00000001, 32'(n_stb));
		chk("wr_addr", 32'h00000012, 32'(wr_addr));
		chk("wr_data", 32'h89ABCDEF, wr_data);
		chk("accept_count", 32'h00000001, 32'(acc));
		$display("test write done");
		// node 1 differs only in which strap is set
		do_cmd(1'b1, 2'h1, 7'h33, 32'h00000000);
		repeat (300) @(negedge clk);
		chk("accept_count", 32'h00000001, 32'(acc));
		chk("wr_data", 32'h89ABCDEF, wr_data);
		$display("test other node done");
		// read: request then reply at the same rate
		fork
			do_cmd(1'b0, 2'h2, 7'h05, 32'h00000000);
			repeat (6) rx_byte(f);
		join
		chk("reply address frame", 32'h000003FE, 32'(f));
		chk("rsp_err", 32'h00000000, 32'(rsp_err));
		chk("rsp_data", 32'h13579BDF, rsp_data);
		chk("rd_addr", 32'h00000005, 32'(rd_addr));
		chk("accept_count", 32'h00000001, 32'(acc));
		$display("test read done");
		// second wire: bad checksum, idle, then a good datagram
		send_dg(8'h01);
		repeat (2000) @(negedge clk);
		chk("bad accept_count", 32'h00000000, 32'(acc2));
		repeat (1500) @(negedge clk);
		send_dg(8'h00);
		repeat (300) @(negedge clk);
		chk("bad accept_count", 32'h00000001, 32'(acc2));
		$display("test checksum done");
		final_report;
	end
endmodule
